// >>> src/tfit_regs.sv
// integration-test register set with APB slave and output muxing
`timescale 1ns/1ps
`default_nettype none
module tfit_regs
   import tfit_pkg::*;
#(
   parameter int DW = tfit_pkg::DATA_W
) (
   input wire logic clk_sys,
   input wire logic reset_n,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // functional values of controllable outputs
   input wire logic [DW-1:0] fnDataM,
   input wire logic [tfit_pkg::ID_W-1:0] fnIdM,
   input wire logic fnFlushComp,
   input wire logic fnFull,
   input wire logic fnAcqComp,
   input wire logic fnSyncReqS,
   input wire logic fnFlushValidS,
   input wire logic fnReadyS,
   // atb master side
   output logic [DW-1:0] atdata_m,
   output logic [tfit_pkg::ID_W-1:0] atid_m,
   input wire logic atready_m,
   input wire logic afvalid_m,
   input wire logic syncreq_m,
   // atb slave side
   input wire logic [DW-1:0] atdata_s,
   input wire logic [tfit_pkg::ID_W-1:0] atid_s,
   input wire logic [tfit_pkg::BYTES_W-1:0] atbytes_s,
   input wire logic atvalid_s,
   input wire logic afready_s,
   input wire logic atwakeup_s,
   output logic atready_s,
   output logic afvalid_s,
   output logic syncreq_s,
   // events and triggers
   output logic flushcomp,
   output logic full,
   output logic acqcomp,
   input wire logic flushin,
   input wire logic trigin,
   // mode status for the functional core
   output logic integrationMode
);
   import tfit_pkg::*;
   // implemented width of the data test registers
   localparam int LW = 1 + DW / 8;

   // ==========================================
   // register state
   logic [LW-1:0] mDataDrive;
   logic [ID_W-1:0] mIdDrive;
   logic [2:0] evtDrive;
   logic [2:0] sHsDrive;
   logic itEnable;

   // ==========================================
   // bus decode
   function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
      hit = (a[11:2] == ofs[11:2]);
   endfunction : hit

   wire access = psel & penable;
   wire wrStb = access & pwrite;
   wire rdStb = access & ~pwrite;
   // test registers only write in integration mode
   wire itWr = wrStb & itEnable;
   wire wrCtl = wrStb & hit(paddr, OFS_ITCTL);
   wire wrMData = itWr & hit(paddr, OFS_MDATA);
   wire wrMId = itWr & hit(paddr, OFS_MID);
   wire wrEvt = itWr & hit(paddr, OFS_EVT);
   wire wrSHs = itWr & hit(paddr, OFS_SHS);
   wire rdMHs = rdStb & hit(paddr, OFS_MHS);
   wire rdTrFl = rdStb & hit(paddr, OFS_TRFL);

   // ==========================================
   // control and drive registers
   // integration enable bit
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         itEnable <= RESET_VAL[0];
         mDataDrive <= '0;
         mIdDrive <= '0;
         evtDrive <= '0;
         sHsDrive <= '0;
      end else begin
         if (wrCtl) itEnable <= pwdata[BIT_ITEN];
         if (wrMData) mDataDrive <= pwdata[LW-1:0];
         if (wrMId) mIdDrive <= pwdata[ID_W-1:0];
         if (wrEvt) evtDrive <= pwdata[2:0];
         if (wrSHs) sHsDrive <= pwdata[2:0];
      end
   end
   assign integrationMode = itEnable;

   // ==========================================
   // edge latches
   logic syncLatch;
   logic flushLatch;
   logic trigLatch;
   tfit_edge_latch u_sync (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .enable(itEnable),
      .sigIn(syncreq_m),
      .clear(rdMHs),
      .flag(syncLatch)
   );
   tfit_edge_latch u_flush (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .enable(itEnable),
      .sigIn(flushin),
      .clear(rdTrFl),
      .flag(flushLatch)
   );
   tfit_edge_latch u_trig (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .enable(itEnable),
      .sigIn(trigin),
      .clear(rdTrFl),
      .flag(trigLatch)
   );

   // ==========================================
   // lane map
   logic [DW-1:0] testDataM;
   logic [LW-1:0] sampledS;
   // written bits go to master data lanes
   tfit_lane_map #(.DW(DW)) u_map (
      .regBits(mDataDrive),
      .busIn(atdata_s),
      .busOut(testDataM),
      .sampled(sampledS)
   );

   // ==========================================
   // output muxing
   // functional value outside integration mode
   assign atdata_m = itEnable ? testDataM : fnDataM;
   assign atid_m = itEnable ? mIdDrive : fnIdM;
   assign flushcomp = itEnable ? evtDrive[BIT_FLCOMP] : fnFlushComp;
   assign full = itEnable ? evtDrive[BIT_FULL] : fnFull;
   assign acqcomp = itEnable ? evtDrive[BIT_ACQ] : fnAcqComp;
   assign syncreq_s = itEnable ? sHsDrive[BIT_SYNC] : fnSyncReqS;
   assign afvalid_s = itEnable ? sHsDrive[BIT_FLUSHV] : fnFlushValidS;
   assign atready_s = itEnable ? sHsDrive[BIT_READY] : fnReadyS;

   // ==========================================
   // read mux
   logic [31:0] mHsVal;
   logic [31:0] trFlVal;
   logic [31:0] sDataVal;
   logic [31:0] sIdVal;
   logic [31:0] sCtlVal;
   logic [31:0] testRd;
   logic [31:0] next_prdata;
   // sync latch plus live flush-valid and ready
   assign mHsVal = {29'h0000_0000, syncLatch, afvalid_m, atready_m};
   assign trFlVal = {30'h0000_0000, flushLatch, trigLatch};
   assign sDataVal = 32'(sampledS);
   assign sIdVal = {25'h000_0000, atid_s};
   assign sCtlVal = {20'h0_0000, atbytes_s, 5'h00, atwakeup_s, afready_s, atvalid_s};
   // write-only registers read zero
   assign testRd = hit(paddr, OFS_MHS) ? mHsVal :
                   hit(paddr, OFS_TRFL) ? trFlVal :
                   hit(paddr, OFS_SDATA) ? sDataVal :
                   hit(paddr, OFS_SID) ? sIdVal :
                   hit(paddr, OFS_SCTL) ? sCtlVal : 32'h0000_0000;
   assign next_prdata = hit(paddr, OFS_ITCTL) ? {31'h0000_0000, itEnable} :
                        itEnable ? testRd : 32'h0000_0000;
   assign pready = 1'b1;
   assign pslverr = 1'b0;
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         prdata <= 32'h0000_0000;
      end else if (psel & ~penable & ~pwrite) begin
         prdata <= next_prdata;
      end
   end

   // ==========================================
   // checks
   // functional reads zero
   a_func_raz: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (psel && !penable && !pwrite && !itEnable && !hit(paddr, OFS_ITCTL)) |=> prdata == 0)
      else $error("functional read not zero");

   a_func_wi: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (wrStb && !itEnable) |=> $stable(mDataDrive) && $stable(evtDrive) && $stable(sHsDrive))
      else $error("functional write took effect");

   a_mode_set: assert property (@(posedge clk_sys) disable iff (!reset_n)
      wrCtl |=> itEnable == $past(pwdata[0]))
      else $error("mode bit not stored");

   a_mid_drive: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (wrMId && !wrCtl) |=> atid_m == $past(pwdata[6:0]))
      else $error("master id not driven");

   a_evt_drive: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (wrEvt && !wrCtl) |=> {flushcomp, full, acqcomp} == $past(pwdata[2:0]))
      else $error("event outputs wrong");

   a_shs_drive: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (wrSHs && !wrCtl) |=> {syncreq_s, afvalid_s, atready_s} == $past(pwdata[2:0]))
      else $error("slave handshake outputs wrong");

   a_mdata_lane: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (wrMData && !wrCtl) |=> atdata_m[DW-1] == $past(pwdata[LW-1]) && atdata_m[0] == $past(pwdata[0]))
      else $error("master data lane wrong");

   a_func_pass: assert property (@(posedge clk_sys) disable iff (!reset_n)
      !itEnable |-> atdata_m == fnDataM && atready_s == fnReadyS)
      else $error("functional value not passed");

   a_sid_read: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (psel && !penable && !pwrite && itEnable && hit(paddr, OFS_SID)) |=> prdata[6:0] == $past(atid_s))
      else $error("slave id read wrong");

   a_sid_upper: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (psel && !penable && !pwrite && itEnable && hit(paddr, OFS_SID))
      |=> prdata[31:ID_W] == '0)
      else $error("slave id upper bits set");

   a_ctl_read: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (psel && !penable && !pwrite && hit(paddr, OFS_ITCTL))
      |=> prdata == 32'($past(itEnable)))
      else $error("control readback wrong");

   // no latched state in functional mode
   a_func_latch: assert property (@(posedge clk_sys) disable iff (!reset_n)
      !$past(itEnable)
      |-> !syncLatch && !flushLatch && !trigLatch)
      else $error("latch set in functional mode");

   a_wo_raz: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (psel && !penable && !pwrite && itEnable && (hit(paddr, OFS_MDATA) || hit(paddr, OFS_MID)
         || hit(paddr, OFS_EVT) || hit(paddr, OFS_SHS)))
      |=> prdata == 0)
      else $error("write-only register not zero");

   // filler bits of the first and last lanes stay low
   a_mdata_fill: assert property (@(posedge clk_sys) disable iff (!reset_n)
      itEnable
      |-> atdata_m[6:1] == 6'h00 && atdata_m[DW-2:DW-8] == 7'h00)
      else $error("master data filler bit set");

   a_sync_read: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (psel && !penable && !pwrite && itEnable && hit(paddr, OFS_MHS))
      |=> prdata[BIT_SYNC] == $past(syncLatch))
      else $error("sync latch read wrong");

   a_sync_clear: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (rdMHs && !syncreq_m)
      |=> !syncLatch)
      else $error("sync latch not cleared");

   a_mhs_read: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (psel && !penable && !pwrite && itEnable && hit(paddr, OFS_MHS))
      |=> prdata[1:0] == $past({afvalid_m, atready_m}))
      else $error("master handshake read wrong");

   a_trfl_read: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (psel && !penable && !pwrite && itEnable && hit(paddr, OFS_TRFL))
      |=> prdata[1:0] == $past({flushLatch, trigLatch}))
      else $error("flush and trigger read wrong");

   a_trfl_clear: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (rdTrFl && !flushin && !trigin)
      |=> !flushLatch && !trigLatch)
      else $error("flush and trigger not cleared");

   a_mode_exit: assert property (@(posedge clk_sys) disable iff (!reset_n)
      $fell(itEnable)
      |=> !syncLatch && !flushLatch && !trigLatch)
      else $error("latch kept after mode exit");

   a_sdata_read: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (psel && !penable && !pwrite && itEnable && hit(paddr, OFS_SDATA))
      |=> prdata[0] == $past(atdata_s[0]) && prdata[LW-1] == $past(atdata_s[DW-1]))
      else $error("slave data end lane wrong");

   a_sdata_mid: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (psel && !penable && !pwrite && itEnable && hit(paddr, OFS_SDATA))
      |=> prdata[LW/2] == $past(atdata_s[8*(LW/2)-1]) && prdata[31:LW] == '0)
      else $error("slave data middle lane wrong");

   a_sctl_read: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (psel && !penable && !pwrite && itEnable && hit(paddr, OFS_SCTL))
      |=> prdata[BYTES_LSB +: BYTES_W] == $past(atbytes_s)
         && prdata[2:0] == $past({atwakeup_s, afready_s, atvalid_s}))
      else $error("slave control read wrong");

   a_func_ctl: assert property (@(posedge clk_sys) disable iff (!reset_n)
      !itEnable
      |-> atid_m == fnIdM && {flushcomp, full, acqcomp} == {fnFlushComp, fnFull, fnAcqComp}
         && {syncreq_s, afvalid_s, atready_s} == {fnSyncReqS, fnFlushValidS, fnReadyS})
      else $error("functional controls not passed");

   // main scenarios reached
   c_enter_mode: cover property (@(posedge clk_sys) disable iff (!reset_n) $rose(itEnable));
   c_exit_mode: cover property (@(posedge clk_sys) disable iff (!reset_n) $fell(itEnable));
   c_sync_read: cover property (@(posedge clk_sys) disable iff (!reset_n) rdMHs && syncLatch);
   c_trig_read: cover property (@(posedge clk_sys) disable iff (!reset_n) rdTrFl && trigLatch);
   c_evt_write: cover property (@(posedge clk_sys) disable iff (!reset_n) wrEvt);
endmodule : tfit_regs
`default_nettype wire

// >>> shared/tfit_pkg.sv
// package of constants for the trace FIFO integration-test register set
// ==========================================
// Operation
// - integration control bit 0 set selects integration mode, clear selects functional
// - functional mode: all test registers read zero, writes discarded
// - master data test write drives master data bits, reads zero
// - data test bit 0 is data bit 0, bits 1..16 are byte-lane top bits
// - implemented data test bits equal one plus data width over eight
// - master sync bit latches on sync rising edge, clears on read or exit
// - master handshake read returns live flush-valid bit 1, ready bit 0
// - master id test write drives seven-bit master id, reads zero
// - event test write drives flush-complete, full, acquisition-complete, reads zero
// - flush and trigger rising edges latch bits 1 and 0, cleared on read/exit
// - slave data test read returns slave data via byte-lane map
// - slave handshake test write drives sync, flush-valid, ready outputs
// - slave id test read returns seven-bit slave id input
// - slave control test read returns bytes, wakeup, flush-ready, valid
package tfit_pkg;
   localparam logic [11:0] OFS_MDATA = 12'hED0;
   localparam logic [11:0] OFS_MHS = 12'hED4;
   localparam logic [11:0] OFS_MID = 12'hED8;
   localparam logic [11:0] OFS_EVT = 12'hEE0;
   localparam logic [11:0] OFS_TRFL = 12'hEE8;
   localparam logic [11:0] OFS_SDATA = 12'hEEC;
   localparam logic [11:0] OFS_SHS = 12'hEF0;
   localparam logic [11:0] OFS_SID = 12'hEF4;
   localparam logic [11:0] OFS_SCTL = 12'hEF8;
   localparam logic [11:0] OFS_ITCTL = 12'hF00;
   localparam int BIT_ITEN = 0;
   localparam int BIT_SYNC = 2;
   localparam int BIT_FLUSHV = 1;
   localparam int BIT_READY = 0;
   localparam int BIT_FLCOMP = 2;
   localparam int BIT_FULL = 1;
   localparam int BIT_ACQ = 0;
   localparam int BIT_FLIN = 1;
   localparam int BIT_TRIG = 0;
   localparam int BIT_WAKE = 2;
   localparam int BYTES_LSB = 8;
   localparam int ID_W = 7;
   localparam int DATA_W = 128;
   localparam int BYTES_W = 4;
   localparam logic [31:0] RESET_VAL = 32'h0000_0000;
endpackage : tfit_pkg

// >>> src/tfit_edge_latch.sv
// sticky rising-edge latch with clear
`timescale 1ns/1ps
`default_nettype none
module tfit_edge_latch (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic enable,
   input wire logic sigIn,
   input wire logic clear,
   output logic flag
);
   import tfit_pkg::*;
   logic prev;
   wire rise = enable & sigIn & ~prev;
   // set wins over clear
   wire next_flag = rise | (flag & ~clear & enable);
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         prev <= 1'b0;
         flag <= 1'b0;
      end else begin
         prev <= sigIn;
         flag <= next_flag;
      end
   end
   a_rise_sets: assert property (@(posedge clk_sys) disable iff (!reset_n)
      rise |=> flag) else $error("edge not latched");
   a_exit_clears: assert property (@(posedge clk_sys) disable iff (!reset_n)
      !enable |=> !flag) else $error("flag held outside mode");
endmodule : tfit_edge_latch
`default_nettype wire

// >>> src/tfit_lane_map.sv
// byte-lane bit map between data bus and test register
`timescale 1ns/1ps
`default_nettype none
module tfit_lane_map #(
   parameter int DW = 128
) (
   input wire logic [DW/8:0] regBits,
   input wire logic [DW-1:0] busIn,
   output logic [DW-1:0] busOut,
   output logic [DW/8:0] sampled
);
   // bit 0 to data 0, bit k to data 8k-1
   assign busOut[0] = regBits[0];
   assign sampled[0] = busIn[0];
   genvar k, j;
   generate
      for (k = 1; k <= DW / 8; k++) begin : g_lane
         assign busOut[8*k-1] = regBits[k];
         assign sampled[k] = busIn[8*k-1];
      end
      for (j = 1; j < DW; j++) begin : g_zero
         if ((j % 8) != 7) begin : g_z
            assign busOut[j] = 1'b0;
         end
      end
   endgenerate
endmodule : tfit_lane_map
`default_nettype wire

// >>> tb/tfit_atb_peer.sv
// far-side model: upstream trace source and downstream sink
`timescale 1ns/1ps
`default_nettype none
module tfit_atb_peer (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic [47:0] cmd,
   output logic atready_m,
   output logic afvalid_m,
   output logic syncreq_m,
   output logic [127:0] atdata_s,
   output logic [6:0] atid_s,
   output logic [3:0] atbytes_s,
   output logic atvalid_s,
   output logic afready_s,
   output logic atwakeup_s
);
   // ==========================================
   // line state, changed only at clock edges
   logic [47:0] cur;
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         cur <= '0;
      end else begin
         cur <= cmd;
      end
   end
   assign {atwakeup_s, afready_s, atvalid_s, syncreq_m, afvalid_m, atready_m} = cur[5:0];
   assign atbytes_s = cur[11:8];
   assign atid_s = cur[18:12];
   // lane top bit per lane, filler bits differ from both
   for (genvar i = 0; i < 16; i++) begin : g_lane
      assign atdata_s[8*i +: 8] = {cur[32+i], 6'h2A, cur[24]};
   end
endmodule : tfit_atb_peer
`default_nettype wire

// >>> tb/testbench.sv
// self-checking bench of the integration-test register set
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module testbench;
   import tfit_pkg::*;
   logic clk_sys, reset_n, psel, penable, pwrite, pready, pslverr, flushin, trigin;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [127:0] fnDataM, atdata_m, atdata_s;
   logic [6:0] fnIdM, atid_m, atid_s;
   logic [3:0] atbytes_s;
   logic [2:0] fnEv, fnHs;
   logic [47:0] cmd;
   logic atready_m, afvalid_m, syncreq_m, atvalid_s, afready_s, atwakeup_s;
   logic atready_s, afvalid_s, syncreq_s, flushcomp, full, acqcomp, integrationMode;
   int n_mismatch, samples_checked;
   localparam logic [11:0] ADRS [11] = '{OFS_MDATA, OFS_MHS, OFS_MID, OFS_EVT, OFS_TRFL,
      OFS_SDATA, OFS_SHS, OFS_SID, OFS_SCTL, OFS_ITCTL, 12'hEE4};
   localparam logic [47:0] PAT [2] = '{48'hA5C3_0102_5A29, 48'h5A3C_FEFD_A5D2};
   tfit_regs u_tfit_regs (.clk_sys, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .fnDataM, .fnIdM, .fnFlushComp(fnEv[2]), .fnFull(fnEv[1]),
      .fnAcqComp(fnEv[0]), .fnSyncReqS(fnHs[2]), .fnFlushValidS(fnHs[1]),
      .fnReadyS(fnHs[0]), .atdata_m, .atid_m, .atready_m, .afvalid_m, .syncreq_m, .atdata_s,
      .atid_s, .atbytes_s, .atvalid_s, .afready_s, .atwakeup_s, .atready_s, .afvalid_s,
      .syncreq_s, .flushcomp, .full, .acqcomp, .flushin, .trigin, .integrationMode);
   tfit_atb_peer u_tfit_atb_peer (.clk_sys, .reset_n, .cmd, .atready_m, .afvalid_m,
      .syncreq_m, .atdata_s, .atid_s, .atbytes_s, .atvalid_s, .afready_s, .atwakeup_s);
   always #25 clk_sys = ~clk_sys;
   // ==========================================
   // helpers
   task automatic finish_test();
      $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : finish_test
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_sys);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (pready !== 1'b1 && n < 16);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 16) begin
         n_mismatch++;
         finish_test();
      end
   endtask : apb
   task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      `CHK(nm, e, rd)
      `CHK("pslverr", 1'b0, pslverr)
   endtask : rdc
   function automatic logic [16:0] lanes(input logic [127:0] v);
      lanes[0] = v[0];
      for (int i = 1; i < 17; i++) lanes[i] = v[8*i-1];
   endfunction : lanes
   task automatic chk_fn();
      @(negedge clk_sys);
      `CHK("atdata_m", fnDataM, atdata_m)
      `CHK("atid_m", fnIdM, atid_m)
      `CHK("events", fnEv, {flushcomp, full, acqcomp})
      `CHK("slave hs", fnHs, {syncreq_s, afvalid_s, atready_s})
   endtask : chk_fn
   // ==========================================
   // scenarios
   task automatic t_func();
      foreach (ADRS[i]) rdc("reset", ADRS[i], 32'h0);
      chk_fn();
      cmd <= 48'hFFFF_FFFF_FFFF;
      flushin <= 1'b1;
      trigin <= 1'b1;
      foreach (ADRS[i]) if (i != 9) apb(1'b1, ADRS[i], 32'hFFFF_FFFF);
      foreach (ADRS[i]) rdc("functional", ADRS[i], 32'h0);
      chk_fn();
      cmd <= 48'h0;
      flushin <= 1'b0;
      trigin <= 1'b0;
   endtask : t_func
   task automatic t_drive();
      apb(1'b1, OFS_ITCTL, 32'hFFFF_FFFF);
      rdc("ctl", OFS_ITCTL, 32'h1);
      `CHK("mode", 1'b1, integrationMode)
      `CHK("discarded", 27'h0, {lanes(atdata_m), atid_m, flushcomp, full, acqcomp})
      apb(1'b1, OFS_MDATA, 32'hFFFD_A5C3);
      apb(1'b1, OFS_MID, 32'hFFFF_FF95);
      apb(1'b1, OFS_EVT, 32'hFFFF_FFFA);
      apb(1'b1, OFS_SHS, 32'hFFFF_FFFD);
      @(negedge clk_sys);
      `CHK("mdata", 17'h1A5C3, lanes(atdata_m))
      `CHK("mdata bus", 128'h8080_0080_0000_8000_8080_8000_0000_0081, atdata_m)
      `CHK("mid", 7'h15, atid_m)
      `CHK("evt", 3'h2, {flushcomp, full, acqcomp})
      `CHK("shs", 3'h5, {syncreq_s, afvalid_s, atready_s})
      foreach (ADRS[i]) if (i inside {0, 2, 3, 6}) rdc("wo", ADRS[i], 32'h0);
   endtask : t_drive
   task automatic t_reset();
      reset_n <= 1'b0;
      repeat (2) @(posedge clk_sys);
      reset_n <= 1'b1;
      `CHK("rst mode", 1'b0, integrationMode)
      apb(1'b1, OFS_ITCTL, 32'h1);
      @(negedge clk_sys);
      `CHK("rst drive", 27'h0, {lanes(atdata_m), atid_m, flushcomp, full, acqcomp})
      `CHK("rst shs", 3'h0, {syncreq_s, afvalid_s, atready_s})
   endtask : t_reset
   task automatic t_sample();
      foreach (PAT[k]) begin
         cmd <= PAT[k];
         repeat (2) @(posedge clk_sys);
         rdc("mhs", OFS_MHS, {30'h0, PAT[k][1:0]});
         rdc("sdata", OFS_SDATA, {15'h0, PAT[k][47:32], PAT[k][24]});
         rdc("sid", OFS_SID, {25'h0, PAT[k][18:12]});
         rdc("sctl", OFS_SCTL, {20'h0, PAT[k][11:8], 5'h0, PAT[k][5:3]});
      end
      cmd <= 48'h0;
   endtask : t_sample
   task automatic t_latch();
      rdc("no old edge", OFS_TRFL, 32'h0);
      cmd <= 48'h4;
      flushin <= 1'b1;
      trigin <= 1'b1;
      repeat (3) @(posedge clk_sys);
      rdc("sync set", OFS_MHS, 32'h4);
      rdc("sync clr", OFS_MHS, 32'h0);
      rdc("trfl set", OFS_TRFL, 32'h3);
      rdc("trfl clr", OFS_TRFL, 32'h0);
      cmd <= 48'h0;
      trigin <= 1'b0;
      repeat (2) @(posedge clk_sys);
      cmd <= 48'h0F3C;
      trigin <= 1'b1;
      repeat (3) @(posedge clk_sys);
      apb(1'b1, OFS_ITCTL, 32'h0);
      chk_fn();
      `CHK("mode off", 1'b0, integrationMode)
      rdc("hidden", OFS_SCTL, 32'h0);
      apb(1'b1, OFS_ITCTL, 32'h1);
      rdc("exit sync", OFS_MHS, 32'h0);
      rdc("exit trfl", OFS_TRFL, 32'h0);
   endtask : t_latch
   initial begin
      clk_sys = 1'b0;
      reset_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h0;
      pwdata = 32'h0;
      fnDataM = {4{32'hC3C3_3C3C}};
      fnIdM = 7'h2A;
      fnEv = 3'h5;
      fnHs = 3'h6;
      cmd = 48'h0;
      flushin = 1'b0;
      trigin = 1'b0;
      n_mismatch = 0;
      samples_checked = 0;
      repeat (2) @(posedge clk_sys);
      reset_n <= 1'b1;
      t_func();
      t_drive();
      t_reset();
      t_sample();
      t_latch();
      finish_test();
   end
endmodule : testbench
`default_nettype wire
